// ### rtl/phub_dma_pkg.sv
// constants, field layouts and state types of the peripheral hub dma
// assumes a single 50 MHz system clock and a 32-bit classic wishbone bus
package phub_dma_pkg;
  localparam int NUM_CH = 24;
  localparam int NUM_TD = 128;
  localparam int NUM_SPOKE = 8;
  localparam int TD_WORDS = 4;
  localparam int SPOKE_LSB = 16;
  localparam int TD_SPACE_BIT = 31;
  // register byte offsets
  localparam logic [11:0] CFG_BASE = 12'h000;
  localparam logic [11:0] TRIG_OFS = 12'h060;
  localparam logic [11:0] CANCEL_OFS = 12'h064;
  localparam logic [11:0] CTRL_OFS = 12'h068;
  localparam logic [11:0] PEND_OFS = 12'h06c;
  localparam logic [11:0] STAT_OFS = 12'h070;
  localparam int TD_POOL_BIT = 11;
  // channel configuration fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_PRIO_LSB = 1;
  localparam int CFG_TD_LSB = 4;
  localparam int CFG_BURST_LSB = 11;
  localparam int CFG_NORR_BIT = 18;
  localparam int CFG_STALL_BIT = 19;
  localparam int CFG_CHSRC_LSB = 20;
  localparam int CFG_CHEN_BIT = 25;
  localparam int CFG_WID_LSB = 26;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int CTRL_FAIR_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // transfer_descriptor words: source, destination, control, next
  localparam logic [1:0] TDW_SRC = 2'h0;
  localparam logic [1:0] TDW_DST = 2'h1;
  localparam logic [1:0] TDW_CTL = 2'h2;
  localparam logic [1:0] TDW_NXT = 2'h3;
  localparam int TD_LEN_LSB = 0;
  localparam int TD_INF_BIT = 17;
  localparam int TD_INCS_BIT = 18;
  localparam int TD_INCD_BIT = 19;
  localparam int TD_IRQ0_BIT = 20;
  localparam int TD_IRQ1_BIT = 21;
  localparam int TD_END_BIT = 7;
  typedef enum logic [1:0] {
    ENG_ARB = 2'b00,
    ENG_LOAD = 2'b01,
    ENG_RUN = 2'b11,
    ENG_FIN = 2'b10
  } eng_state_e;
  typedef enum logic [1:0] {
    OWN_NONE = 2'b00,
    OWN_CPU = 2'b01,
    OWN_RD = 2'b11,
    OWN_WR = 2'b10
  } owner_e;
endpackage : phub_dma_pkg

// ### rtl/phub_dma.sv
// peripheral hub: processor and dma masters routed over eight spokes
// assumes spoke slaves qualify ack with cyc and answer every request
//
// The implementer's own choices: the Wishbone slave port and the address map.

module phub_dma
  import phub_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpuReq,
  input wire logic cpuWe,
  input wire logic [31:0] cpuAddr,
  input wire logic [31:0] cpuWdata,
  input wire logic [3:0] cpuSel,
  output logic cpuAck,
  output logic [31:0] cpuRdata,
  input wire logic [NUM_CH-1:0] trigIn,
  output logic [NUM_SPOKE-1:0] spokeCyc,
  output logic [NUM_SPOKE-1:0] spokeWe,
  output logic [NUM_SPOKE*32-1:0] spokeAddr,
  output logic [NUM_SPOKE*32-1:0] spokeWdata,
  output logic [NUM_SPOKE*4-1:0] spokeSel,
  input wire logic [NUM_SPOKE-1:0] spokeAck,
  input wire logic [NUM_SPOKE*32-1:0] spokeRdata,
  output logic [NUM_CH-1:0] termOut0,
  output logic [NUM_CH-1:0] termOut1
);
  function automatic logic [2:0] spokeOf(input logic [31:0] a);
    return a[SPOKE_LSB +: 3];
  endfunction : spokeOf

  function automatic logic [3:0] laneSel(input logic [2:0] n);
    case (n)
      3'd1: return 4'h1;
      3'd2: return 4'h3;
      3'd3: return 4'h7;
      default: return 4'hf;
    endcase
  endfunction : laneSel

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // descriptor pool, four words each
  logic [31:0] tdMem [NUM_TD*TD_WORDS];
  logic [31:0] cfg_reg [NUM_CH];
  logic [31:0] ctrl_reg;
  logic [NUM_CH-1:0] pend_reg;
  logic [NUM_CH-1:0] trigPrev;
  logic [NUM_CH-1:0] active;
  logic [NUM_CH-1:0] ld;
  logic [NUM_CH-1:0] doneMask;
  logic [6:0] curTd [NUM_CH];
  logic [31:0] srcPtr [NUM_CH];
  logic [31:0] dstPtr [NUM_CH];
  logic [31:0] ctlW [NUM_CH];
  logic [7:0] nxtW [NUM_CH];
  logic [16:0] rem [NUM_CH];
  eng_state_e engState;
  logic [4:0] engCh;
  logic [1:0] stepCnt;
  logic [6:0] burstLeft;
  logic [5:0] fairCnt;
  logic [4:0] rrLast [8];
  logic cancelHit;
  logic rdOut, wrOut, holdV;
  logic [2:0] rdB, holdB, wrB;
  logic [31:0] hold, wrData;
  owner_e owner [NUM_SPOKE];
  logic [NUM_SPOKE-1:0] dmaWait;

  logic wbHit, wbWr, dmaTdWr, wbTdBlock;
  logic [NUM_CH-1:0] cpuTrig, cancelMask, reqV, startMask;
  logic anyWin;
  logic [4:0] win;
  logic [2:0] winLvl;
  logic rdOn, wrOn, cpuOn, rdAck, wrAck;
  logic [31:0] rdData;
  logic [2:0] beatB;
  logic readsLeft, stopReq, tdDone, canRead;

  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign dmaTdWr = engState == ENG_RUN && wrOut && dstPtr[engCh][TD_SPACE_BIT];
  // a dma pool write owns the pool port; the bus waits one cycle
  assign wbTdBlock = wbHit && wb_adr_i[TD_POOL_BIT] && dmaTdWr;
  assign wbWr = wbHit && !wbTdBlock && wb_we_i;
  assign cpuTrig = (wbWr && wb_adr_i == TRIG_OFS) ?
      wb_dat_i[NUM_CH-1:0] : '0;
  assign cancelMask = (wbWr && wb_adr_i == CANCEL_OFS) ?
      wb_dat_i[NUM_CH-1:0] : '0;

  // register slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= CTRL_RESET;
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_reg[c] <= CFG_RESET;
      end
    end else begin
      wb_ack_o <= wbHit && !wbTdBlock;
      if (wbHit && !wbTdBlock) begin
        wb_dat_o <= 32'h0000_0000;
        if (wb_adr_i[TD_POOL_BIT]) begin
          wb_dat_o <= tdMem[wb_adr_i[10:2]];
        end else if (wb_adr_i[11:2] < 10'(NUM_CH)) begin
          wb_dat_o <= cfg_reg[wb_adr_i[6:2]];
          if (wb_we_i) begin
            cfg_reg[wb_adr_i[6:2]] <=
                merge(cfg_reg[wb_adr_i[6:2]], wb_dat_i, wb_sel_i);
          end
        end else if (wb_adr_i == CTRL_OFS) begin
          wb_dat_o <= ctrl_reg;
          if (wb_we_i) begin
            ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i);
          end
        end else if (wb_adr_i == PEND_OFS) begin
          wb_dat_o <= {8'h00, pend_reg};
        end else if (wb_adr_i == STAT_OFS) begin
          wb_dat_o <= {8'h00, active};
        end
      end
    end
  end

  // pool written by the bus or by the dma engine
  always_ff @(posedge clk) begin
    if (dmaTdWr) begin
      tdMem[dstPtr[engCh][10:2]] <= merge(tdMem[dstPtr[engCh][10:2]],
          wrData, laneSel(wrB));
    end else if (wbWr && wb_adr_i[TD_POOL_BIT]) begin
      tdMem[wb_adr_i[10:2]] <= merge(tdMem[wb_adr_i[10:2]], wb_dat_i,
          wb_sel_i);
    end
  end

  // trigger edges, chained completion; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= '0;
      trigPrev <= '0;
    end else begin
      trigPrev <= trigIn;
      for (int c = 0; c < NUM_CH; c++) begin
        logic setB;
        setB = (trigIn[c] && !trigPrev[c]) || cpuTrig[c] ||
            (cfg_reg[c][CFG_CHEN_BIT] &&
             doneMask[cfg_reg[c][CFG_CHSRC_LSB +: 5]]);
        if (setB && cfg_reg[c][CFG_EN_BIT]) begin
          pend_reg[c] <= 1'b1;
        end else if (startMask[c] || cancelMask[c]) begin
          pend_reg[c] <= 1'b0;
        end
      end
    end
  end

  // channel arbitration at burst boundaries
  always_comb begin
    logic [7:0] lvlReq;
    logic [2:0] fav;
    int c;
    lvlReq = '0;
    fav = 3'd7;
    c = 0;
    anyWin = 1'b0;
    win = '0;
    winLvl = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      reqV[i] = cfg_reg[i][CFG_EN_BIT] && !cfg_reg[i][CFG_STALL_BIT] &&
          (pend_reg[i] || active[i]);
      if (reqV[i]) begin
        lvlReq[cfg_reg[i][CFG_PRIO_LSB +: 3]] = 1'b1;
      end
    end
    for (int l = 7; l >= 0; l--) begin
      if (lvlReq[l]) begin
        winLvl = 3'(l);
      end
    end
    // favoured level from trailing zeros of the counter
    for (int b = 4; b >= 0; b--) begin
      if (fairCnt[b]) begin
        fav = 3'(b + 2);
      end
    end
    // fairness only below levels 0 and 1, only if enabled
    if (ctrl_reg[CTRL_FAIR_BIT] && !lvlReq[0] && !lvlReq[1] &&
        lvlReq[fav]) begin
      winLvl = fav;
    end
    // rotate from the last winner of the level
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      c = int'(rrLast[winLvl]) + 1 + i;
      if (c >= NUM_CH) begin
        c = c - NUM_CH;
      end
      if (reqV[c] && cfg_reg[c][CFG_PRIO_LSB +: 3] == winLvl) begin
        anyWin = 1'b1;
        win = 5'(c);
      end
    end
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (reqV[i] && cfg_reg[i][CFG_NORR_BIT] &&
          cfg_reg[i][CFG_PRIO_LSB +: 3] == winLvl) begin
        win = 5'(i);
      end
    end
    startMask = '0;
    if (engState == ENG_ARB && anyWin && !active[win]) begin
      startMask[win] = 1'b1;
    end
  end

  // spoke ownership and engine beat sizing
  always_comb begin
    logic [2:0] w;
    w = 3'd0;
    rdOn = 1'b0;
    wrOn = 1'b0;
    cpuOn = 1'b0;
    rdAck = 1'b0;
    wrAck = 1'b0;
    rdData = 32'h0000_0000;
    for (int k = 0; k < NUM_SPOKE; k++) begin
      rdOn = rdOn | (owner[k] == OWN_RD);
      wrOn = wrOn | (owner[k] == OWN_WR);
      cpuOn = cpuOn | (owner[k] == OWN_CPU);
      if (owner[k] == OWN_RD && spokeAck[k]) begin
        rdAck = 1'b1;
        rdData = spokeRdata[k*32 +: 32];
      end
      if (owner[k] == OWN_WR && spokeAck[k]) begin
        wrAck = 1'b1;
      end
    end
    // beat of 1..4 bytes, trimmed to burst and length
    w = 3'(cfg_reg[engCh][CFG_WID_LSB +: 2]) + 3'd1;
    if (7'(w) > burstLeft) begin
      w = burstLeft[2:0];
    end
    if (!ctlW[engCh][TD_INF_BIT] && 17'(w) > rem[engCh]) begin
      w = rem[engCh][2:0];
    end
    beatB = w;
    readsLeft = burstLeft != 7'd0 &&
        (ctlW[engCh][TD_INF_BIT] || rem[engCh] != 17'd0);
    stopReq = cfg_reg[engCh][CFG_STALL_BIT] || cancelHit ||
        !cfg_reg[engCh][CFG_EN_BIT];
    tdDone = !ctlW[engCh][TD_INF_BIT] && rem[engCh] == 17'd0;
    // next read overlaps the write unless both use the same spoke
    canRead = engState == ENG_RUN && !rdOut && !holdV && readsLeft &&
        !stopReq && !(wrOut && !dstPtr[engCh][TD_SPACE_BIT] &&
        spokeOf(dstPtr[engCh]) == spokeOf(srcPtr[engCh]));
  end

  // per-spoke grant between processor and dma
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuAck <= 1'b0;
      cpuRdata <= 32'h0000_0000;
      spokeCyc <= '0;
      spokeWe <= '0;
      spokeAddr <= '0;
      spokeWdata <= '0;
      spokeSel <= '0;
      dmaWait <= '0;
      for (int k = 0; k < NUM_SPOKE; k++) begin
        owner[k] <= OWN_NONE;
      end
    end else begin
      cpuAck <= 1'b0;
      for (int k = 0; k < NUM_SPOKE; k++) begin
        logic cpuW, rdW, wrW;
        cpuW = cpuReq && !cpuAck && !cpuOn && spokeOf(cpuAddr) == 3'(k);
        rdW = rdOut && !rdOn && spokeOf(srcPtr[engCh]) == 3'(k);
        wrW = wrOut && !wrOn && !dstPtr[engCh][TD_SPACE_BIT] &&
            spokeOf(dstPtr[engCh]) == 3'(k);
        if (owner[k] == OWN_NONE) begin
          // processor first unless dma already lost once
          if (cpuW && !(dmaWait[k] && (rdW || wrW))) begin
            owner[k] <= OWN_CPU;
            dmaWait[k] <= rdW || wrW;
            spokeCyc[k] <= 1'b1;
            spokeWe[k] <= cpuWe;
            spokeAddr[k*32 +: 32] <= cpuAddr;
            spokeWdata[k*32 +: 32] <= cpuWdata;
            spokeSel[k*4 +: 4] <= cpuSel;
          end else if (rdW) begin
            owner[k] <= OWN_RD;
            dmaWait[k] <= 1'b0;
            spokeCyc[k] <= 1'b1;
            spokeWe[k] <= 1'b0;
            spokeAddr[k*32 +: 32] <= srcPtr[engCh];
            spokeSel[k*4 +: 4] <= laneSel(rdB);
          end else if (wrW) begin
            owner[k] <= OWN_WR;
            dmaWait[k] <= 1'b0;
            spokeCyc[k] <= 1'b1;
            spokeWe[k] <= 1'b1;
            spokeAddr[k*32 +: 32] <= dstPtr[engCh];
            spokeWdata[k*32 +: 32] <= wrData;
            spokeSel[k*4 +: 4] <= laneSel(wrB);
          end
        end else if (spokeAck[k]) begin
          owner[k] <= OWN_NONE;
          spokeCyc[k] <= 1'b0;
          if (owner[k] == OWN_CPU) begin
            cpuAck <= 1'b1;
            cpuRdata <= spokeRdata[k*32 +: 32];
          end
        end
      end
    end
  end

  // engine idles in arbitration until a channel is triggered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      engState <= ENG_ARB;
      engCh <= '0;
      stepCnt <= '0;
      burstLeft <= '0;
      fairCnt <= '0;
      cancelHit <= 1'b0;
      rdOut <= 1'b0;
      wrOut <= 1'b0;
      holdV <= 1'b0;
      rdB <= '0;
      holdB <= '0;
      wrB <= '0;
      hold <= '0;
      wrData <= '0;
      active <= '0;
      ld <= '0;
      doneMask <= '0;
      termOut0 <= '0;
      termOut1 <= '0;
      for (int l = 0; l < 8; l++) begin
        rrLast[l] <= 5'(NUM_CH - 1);
      end
      for (int c = 0; c < NUM_CH; c++) begin
        curTd[c] <= '0;
        srcPtr[c] <= '0;
        dstPtr[c] <= '0;
        ctlW[c] <= '0;
        nxtW[c] <= '0;
        rem[c] <= '0;
      end
    end else begin
      termOut0 <= '0;
      termOut1 <= '0;
      doneMask <= '0;
      // cancel idle channels at once, the running one at burst end
      for (int c = 0; c < NUM_CH; c++) begin
        if (cancelMask[c] && !(5'(c) == engCh && engState != ENG_ARB)) begin
          active[c] <= 1'b0;
          ld[c] <= 1'b0;
        end
      end
      if (engState != ENG_ARB && cancelMask[engCh]) begin
        cancelHit <= 1'b1;
      end
      case (engState)
        ENG_ARB: begin
          if (anyWin) begin
            engCh <= win;
            fairCnt <= fairCnt + 6'd1;
            rrLast[winLvl] <= win;
            cancelHit <= 1'b0;
            stepCnt <= '0;
            if (!active[win]) begin
              active[win] <= 1'b1;
              ld[win] <= 1'b0;
              curTd[win] <= cfg_reg[win][CFG_TD_LSB +: 7];
            end
            engState <= ENG_LOAD;
          end
        end
        ENG_LOAD: begin
          if (ld[engCh]) begin
            // burst field of zero is treated as one byte
            burstLeft <= (cfg_reg[engCh][CFG_BURST_LSB +: 7] == 7'd0) ?
                7'd1 : cfg_reg[engCh][CFG_BURST_LSB +: 7];
            engState <= ENG_RUN;
          end else begin
            // descriptor fetched from the shared pool
            stepCnt <= stepCnt + 2'd1;
            case (stepCnt)
              TDW_SRC: srcPtr[engCh] <= tdMem[{curTd[engCh], TDW_SRC}];
              TDW_DST: dstPtr[engCh] <= tdMem[{curTd[engCh], TDW_DST}];
              TDW_CTL: begin
                ctlW[engCh] <= tdMem[{curTd[engCh], TDW_CTL}];
                rem[engCh] <= tdMem[{curTd[engCh], TDW_CTL}][TD_LEN_LSB +: 17];
              end
              default: begin
                nxtW[engCh] <= tdMem[{curTd[engCh], TDW_NXT}][7:0];
                ld[engCh] <= 1'b1;
              end
            endcase
          end
        end
        ENG_RUN: begin
          if (canRead) begin
            rdOut <= 1'b1;
            rdB <= beatB;
            burstLeft <= burstLeft - 7'(beatB);
            if (!ctlW[engCh][TD_INF_BIT]) begin
              rem[engCh] <= rem[engCh] - 17'(beatB);
            end
          end
          if (rdAck) begin
            rdOut <= 1'b0;
            hold <= rdData;
            holdB <= rdB;
            holdV <= 1'b1;
            if (ctlW[engCh][TD_INCS_BIT]) begin
              srcPtr[engCh] <= srcPtr[engCh] + 32'(rdB);
            end
          end
          if (holdV && !wrOut) begin
            wrOut <= 1'b1;
            wrData <= hold;
            wrB <= holdB;
            holdV <= 1'b0;
          end
          if (wrAck || dmaTdWr) begin
            wrOut <= 1'b0;
            if (ctlW[engCh][TD_INCD_BIT]) begin
              dstPtr[engCh] <= dstPtr[engCh] + 32'(wrB);
            end
          end
          // burst over: drain, then arbitrate again
          if (!canRead && !rdOut && !holdV && !wrOut &&
              (!readsLeft || stopReq)) begin
            if (cancelHit) begin
              active[engCh] <= 1'b0;
              ld[engCh] <= 1'b0;
              engState <= ENG_ARB;
            end else if (tdDone) begin
              engState <= ENG_FIN;
            end else begin
              engState <= ENG_ARB;
            end
          end
        end
        default: begin
          // one pulse per enabled interrupt output
          termOut0[engCh] <= ctlW[engCh][TD_IRQ0_BIT];
          termOut1[engCh] <= ctlW[engCh][TD_IRQ1_BIT];
          doneMask[engCh] <= 1'b1;
          ld[engCh] <= 1'b0;
          // continue with the next descriptor unless chain ends
          if (nxtW[engCh][TD_END_BIT]) begin
            active[engCh] <= 1'b0;
          end else begin
            curTd[engCh] <= nxtW[engCh][6:0];
          end
          engState <= ENG_ARB;
        end
      endcase
    end
  end
endmodule : phub_dma

// ### test/spoke_slave_model.sv
// spoke slaves: one small word memory, sixteen words for each of the eight spokes
// assumes requests held until ack; odd spokes answer two cycles late
module spoke_slave_model
  import phub_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_SPOKE-1:0] spokeCyc,
  input wire logic [NUM_SPOKE-1:0] spokeWe,
  input wire logic [NUM_SPOKE*32-1:0] spokeAddr,
  input wire logic [NUM_SPOKE*32-1:0] spokeWdata,
  input wire logic [NUM_SPOKE*4-1:0] spokeSel,
  output logic [NUM_SPOKE-1:0] spokeAck,
  output logic [NUM_SPOKE*32-1:0] spokeRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [128];
  logic [1:0] waitCnt [NUM_SPOKE];
  logic [6:0] idx;
  initial foreach (mem[i]) mem[i] = '0;
  // idle read data toggles so a stale word never passes for an answer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spokeAck <= '0;
      spokeRdata <= '0;
      foreach (waitCnt[k]) waitCnt[k] <= '0;
    end else begin
      for (int k = 0; k < NUM_SPOKE; k++) begin
        idx = {k[2:0], spokeAddr[k*32+2 +: 4]};
        spokeAck[k] <= 1'b0;
        spokeRdata[k*32 +: 32] <= ~spokeRdata[k*32 +: 32];
        if (spokeCyc[k] && !spokeAck[k]) begin
          if (waitCnt[k] == {k[0], 1'b0}) begin
            waitCnt[k] <= '0;
            spokeAck[k] <= 1'b1;
            spokeRdata[k*32 +: 32] <= mem[idx];
            // byte lanes honour the select so narrow beats stay narrow
            for (int b = 0; b < 4; b++)
              if (spokeWe[k] && spokeSel[k*4+b])
                mem[idx][b*8 +: 8] <= spokeWdata[k*32+b*8 +: 8];
          end else waitCnt[k] <= waitCnt[k] + 2'h1;
        end
      end
    end
  end
endmodule : spoke_slave_model

// ### test/phub_dma_chk.sv
// checker: bus handshakes and quiet reset of the hub
// assumes one clock domain; bound to every phub_dma instance
module phub_dma_chk
  import phub_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cpuReq,
  input wire logic cpuAck,
  input wire logic [NUM_SPOKE-1:0] spokeCyc,
  input wire logic [NUM_SPOKE-1:0] spokeAck,
  input wire logic [NUM_SPOKE*32-1:0] spokeAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic anyAck;
  assign anyAck = |spokeAck;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  reset_idle_a:
    assert property ($rose(rst_n) |-> !spokeCyc && !cpuAck)
    else $error("bus activity right after reset");
  wb_answer_a:
    assert property ($rose(wb_stb_i) |-> ##[1:2] wb_ack_o)
    else $error("register access not answered");
  wb_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack longer than one cycle");
  cpu_follow_a:
    assert property (cpuAck |-> $past(anyAck))
    else $error("processor ack without spoke ack");
  cpu_served_a:
    assert property ($rose(cpuReq) |-> ##[2:300] cpuAck)
    else $error("processor request starved");
  cpu_pulse_a:
    assert property (cpuAck |=> !cpuAck)
    else $error("processor ack longer than one cycle");
  for (genvar k = 0; k < NUM_SPOKE; k++) begin : g_spoke
    spoke_hold_a:
      assert property (spokeCyc[k] && !spokeAck[k] |=> spokeCyc[k]
        && $stable(spokeAddr[k*32 +: 32]))
      else $error("spoke request changed before ack");
    spoke_release_a:
      assert property (spokeCyc[k] && spokeAck[k] |=> !spokeCyc[k])
      else $error("spoke request held after ack");
  end
endmodule : phub_dma_chk

bind phub_dma phub_dma_chk phub_dma_chk_inst (.clk(clk), .rst_n(rst_n),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpuReq(cpuReq),
  .cpuAck(cpuAck), .spokeCyc(spokeCyc), .spokeAck(spokeAck),
  .spokeAddr(spokeAddr));

// ### test/tb_top.sv
// top bench: register bus, processor port, triggers and dma copies
// assumes the spoke slave model stands behind all eight spokes
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import phub_dma_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbWe = 1'b0;
  logic [3:0] wbSel = 4'h0;
  logic [11:0] wbAdr = '0;
  logic [31:0] wbDatW = '0;
  logic [31:0] wbDatR, cpuRdata, rd;
  logic wbAck, cpuAck;
  logic cpuReq = 1'b0;
  logic cpuWe = 1'b0;
  logic [31:0] cpuAddr = '0;
  logic [31:0] cpuWdata = '0;
  logic [NUM_CH-1:0] trigIn = '0;
  logic [NUM_CH-1:0] termOut0, termOut1;
  logic [NUM_SPOKE-1:0] spokeCyc, spokeWe, spokeAck;
  logic [NUM_SPOKE*32-1:0] spokeAddr, spokeWdata, spokeRdata;
  logic [NUM_SPOKE*4-1:0] spokeSel;
  int failCount = 0;
  int testsRun = 0;

  initial forever #10 clk = ~clk;

  phub_dma phub_dma_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW),
    .wb_sel_i(wbSel), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .cpuReq(cpuReq),
    .cpuWe(cpuWe), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuSel(4'hf),
    .cpuAck(cpuAck), .cpuRdata(cpuRdata), .trigIn(trigIn),
    .spokeCyc(spokeCyc), .spokeWe(spokeWe), .spokeAddr(spokeAddr),
    .spokeWdata(spokeWdata), .spokeSel(spokeSel), .spokeAck(spokeAck),
    .spokeRdata(spokeRdata), .termOut0(termOut0), .termOut1(termOut1));
  spoke_slave_model spoke_slave_model_inst (.clk(clk), .rst_n(rst_n),
    .spokeCyc(spokeCyc), .spokeWe(spokeWe), .spokeAddr(spokeAddr),
    .spokeWdata(spokeWdata), .spokeSel(spokeSel), .spokeAck(spokeAck),
    .spokeRdata(spokeRdata));

  task automatic wrap_up;
    if (failCount == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic give_up;
    failCount++;
    wrap_up;
  endtask : give_up

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check32

  task automatic wb_xfer(input logic we, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hf;
    wbAdr <= a;
    wbDatW <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 300);
    if (n >= 300) give_up;
    rd = wbDatR;
    wbCyc <= 1'b0;
  endtask : wb_xfer

  task automatic cpu_xfer(input logic we, input logic [31:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk);
    cpuReq <= 1'b1;
    cpuWe <= we;
    cpuAddr <= a;
    cpuWdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpuAck !== 1'b1 && n < 300);
    if (n >= 300) give_up;
    rd = cpuRdata;
    cpuReq <= 1'b0;
  endtask : cpu_xfer

  task automatic wait_term(input int ch, input bit second);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk);
      if ((second ? termOut1[ch] : termOut0[ch]) === 1'b1) break;
    end
    if (n >= 2000) give_up;
  endtask : wait_term

  task automatic put_td(input int td, input logic [31:0] s, t, c, x);
    wb_xfer(1'b1, 12'h800 + 12'(td * 16), s);
    wb_xfer(1'b1, 12'h804 + 12'(td * 16), t);
    wb_xfer(1'b1, 12'h808 + 12'(td * 16), c | (32'h1 << TD_INCS_BIT)
      | (32'h1 << TD_INCD_BIT));
    wb_xfer(1'b1, 12'h80c + 12'(td * 16), x);
  endtask : put_td

  // word beats, four-byte bursts
  function automatic logic [31:0] cfg(input int prio, input int td);
    return (32'h1 << CFG_EN_BIT) | (32'(prio) << CFG_PRIO_LSB)
      | (32'(td) << CFG_TD_LSB) | (32'h4 << CFG_BURST_LSB)
      | (32'h3 << CFG_WID_LSB);
  endfunction : cfg

  task automatic s_reset;
    wb_xfer(1'b0, CTRL_OFS, '0);
    check32(rd, CTRL_RESET);
    wb_xfer(1'b0, STAT_OFS, '0);
    check32(rd, 32'h0);
    wb_xfer(1'b0, PEND_OFS, '0);
    check32(rd, 32'h0);
    wb_xfer(1'b0, CFG_BASE + 12'h05c, '0);
    check32(rd, CFG_RESET);
    wb_xfer(1'b0, 12'h0fc, '0);
    check32(rd, 32'h0);
  endtask : s_reset

  task automatic s_cpu;
    for (int k = 0; k < NUM_SPOKE; k++)
      cpu_xfer(1'b1, {13'h0, k[2:0], 16'h0020}, 32'h5a00_0000 + k);
    for (int k = 0; k < NUM_SPOKE; k++) begin
      cpu_xfer(1'b0, {13'h0, k[2:0], 16'h0020}, '0);
      check32(rd, 32'h5a00_0000 + k);
    end
  endtask : s_cpu

  task automatic s_dma;
    cpu_xfer(1'b1, 32'h0001_0000, 32'ha5a5_0001);
    cpu_xfer(1'b1, 32'h0001_0004, 32'ha5a5_0002);
    put_td(0, 32'h0001_0000, 32'h0002_0000,
      32'h8 | (32'h1 << TD_IRQ0_BIT), 32'h80);
    wb_xfer(1'b1, CFG_BASE, cfg(0, 0));
    wb_xfer(1'b1, TRIG_OFS, 32'h1);
    wait_term(0, 1'b0);
    cpu_xfer(1'b0, 32'h0002_0000, '0);
    check32(rd, 32'ha5a5_0001);
    cpu_xfer(1'b0, 32'h0002_0004, '0);
    check32(rd, 32'ha5a5_0002);
  endtask : s_dma

  task automatic s_chain;
    put_td(1, 32'h0001_0000, 32'h0004_0000, 32'h4, 32'h2);
    put_td(2, 32'h0001_0004, 32'h0004_0004,
      32'h4 | (32'h1 << TD_IRQ1_BIT), 32'h80);
    wb_xfer(1'b1, CFG_BASE + 12'h004, cfg(3, 1));
    trigIn <= 24'h2;
    wait_term(1, 1'b1);
    trigIn <= 24'h0;
    cpu_xfer(1'b0, 32'h0004_0000, '0);
    check32(rd, 32'ha5a5_0001);
    cpu_xfer(1'b0, 32'h0004_0004, '0);
    check32(rd, 32'ha5a5_0002);
  endtask : s_chain

  // dma writes a word into the descriptor pool, read back over the bus
  task automatic s_nest;
    put_td(3, 32'h0001_0000, 32'h8000_0050,
      32'h4 | (32'h1 << TD_IRQ0_BIT), 32'h80);
    wb_xfer(1'b1, CFG_BASE + 12'h008, cfg(1, 3));
    wb_xfer(1'b1, TRIG_OFS, 32'h4);
    wait_term(2, 1'b0);
    wb_xfer(1'b0, 12'h850, '0);
    check32(rd, 32'ha5a5_0001);
    wb_xfer(1'b0, STAT_OFS, '0);
    check32(rd, 32'h0);
  endtask : s_nest

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    s_reset;
    s_cpu;
    s_dma;
    s_chain;
    s_nest;
    wrap_up;
  end
endmodule : tb_top
